// file: inc/afc_pkg.sv
// constants, register map and state codes for the fifo host controller
package afc_pkg;

  // ----------------------------------------
  // clock and pin timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DATA_W = 9;
  localparam int unsigned CNT_W = 8;
  // least times in ns; plain defaults, tune to the part in use
  localparam int unsigned T_CLEAR_LOW_NS = 100;
  localparam int unsigned T_STROBE_SETUP_BEFORE_CLEAR_RELEASE_NS = 20;
  localparam int unsigned T_STROBE_HOLD_AFTER_CLEAR_RELEASE_NS = 20;
  localparam int unsigned T_DATA_SETUP_NS = 20;
  localparam int unsigned T_STROBE_LOW_NS = 80;
  localparam int unsigned T_RECOVER_NS = 60;
  localparam int unsigned T_REPLAY_LOW_NS = 60;

  // least times round up to whole cycles
  localparam int unsigned C_CLEAR_LOW = (T_CLEAR_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_CLR_SETUP =
    (T_STROBE_SETUP_BEFORE_CLEAR_RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_CLR_HOLD =
    (T_STROBE_HOLD_AFTER_CLEAR_RELEASE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_DATA_SETUP = (T_DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_STROBE_LOW = (T_STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_RECOVER = (T_RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_REPLAY_LOW = (T_REPLAY_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned C_CLR_TOTAL = (C_CLEAR_LOW > C_CLR_SETUP) ? C_CLEAR_LOW : C_CLR_SETUP;

  // counter load values (count down to zero)
  localparam logic [CNT_W-1:0] LD_CLR_LOW = CNT_W'(C_CLR_TOTAL - 1);
  localparam logic [CNT_W-1:0] LD_CLR_HOLD = CNT_W'(C_CLR_HOLD - 1);
  localparam logic [CNT_W-1:0] LD_DATA_SETUP = CNT_W'(C_DATA_SETUP - 1);
  localparam logic [CNT_W-1:0] LD_STROBE_LOW = CNT_W'(C_STROBE_LOW - 1);
  localparam logic [CNT_W-1:0] LD_RECOVER = CNT_W'(C_RECOVER - 1);
  localparam logic [CNT_W-1:0] LD_REPLAY_LOW = CNT_W'(C_REPLAY_LOW - 1);

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_WDATA = 12'h004;
  localparam logic [ADDR_W-1:0] REG_RDATA = 12'h008;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h00C;

  localparam int unsigned CTRL_CLEAR = 0;
  localparam int unsigned CTRL_READ = 1;
  localparam int unsigned CTRL_REPLAY = 2;
  localparam int unsigned CTRL_CHAIN = 3;
  localparam logic CHAIN_RST = 1'b0;

  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_READY = 1;
  localparam int unsigned ST_FULL_N = 2;
  localparam int unsigned ST_EMPTY_N = 3;
  localparam int unsigned ST_HALF_N = 4;
  localparam int unsigned ST_RVALID = 5;
  localparam int unsigned ST_REFUSED = 6;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    AFC_IDLE = 4'h0,
    AFC_CLR_LOW = 4'h1,
    AFC_CLR_HOLD = 4'h2,
    AFC_WR_SETUP = 4'h3,
    AFC_WR_LOW = 4'h4,
    AFC_WR_HIGH = 4'h5,
    AFC_RD_LOW = 4'h6,
    AFC_RD_HIGH = 4'h7,
    AFC_RT_LOW = 4'h8,
    AFC_RT_HIGH = 4'h9
  } afc_state_t;

endpackage

// file: rtl/afc_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module afc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      logic out_r;
      logic out_nxt;

      // first stage feeds only the second; the filter looks at stages two and three
      always_comb begin
        out_nxt = out_r;
        if (s2_r == s3_r) begin
          out_nxt = s3_r;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          out_r <= 1'b1;
        end else begin
          s1_r <= pin_in[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          out_r <= out_nxt;
        end
      end

      assign level_out[i] = out_r;
    end
  endgenerate

endmodule

// file: rtl/afc_host.sv
// apb-controlled host sequencer for the strobe-driven 9-bit fifo
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module afc_host
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [afc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fifo control pins
  output logic clear_in_n,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic replay_n,
  output logic chain_in_n,
  output logic [afc_pkg::DATA_W-1:0] write_data,
  // fifo status and data pins
  input wire logic full_flag_n,
  input wire logic empty_flag_n,
  input wire logic half_level_flag_n,
  input wire logic [afc_pkg::DATA_W-1:0] read_data
);

  import afc_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [DATA_W+2:0] pins_sync;
  logic full_s;
  logic empty_s;
  logic half_s;
  logic [DATA_W-1:0] rdata_s;

  afc_sync #(.WIDTH(DATA_W + 3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({read_data, half_level_flag_n, empty_flag_n, full_flag_n}),
    .level_out(pins_sync)
  );

  assign full_s = pins_sync[0];
  assign empty_s = pins_sync[1];
  assign half_s = pins_sync[2];
  assign rdata_s = pins_sync[DATA_W+2:3];

  // ----------------------------------------
  // state
  // ----------------------------------------
  afc_state_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic clear_n_r, clear_n_nxt;
  logic wr_n_r, wr_n_nxt;
  logic rd_n_r, rd_n_nxt;
  logic replay_n_r, replay_n_nxt;
  logic chain_r, chain_nxt;
  logic chain_in_n_r, chain_in_n_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rword_r, rword_nxt;
  logic ready_r, ready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic refused_r, refused_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic rt_go;
  logic clr_go;
  logic rd_done;
  logic cnt_zero;

  // ----------------------------------------
  // bus decode and sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    clear_n_nxt = clear_n_r;
    wr_n_nxt = wr_n_r;
    rd_n_nxt = rd_n_r;
    replay_n_nxt = replay_n_r;
    chain_nxt = chain_r;
    wdata_nxt = wdata_r;
    rword_nxt = rword_r;
    ready_nxt = ready_r;
    rvalid_nxt = rvalid_r;
    refused_nxt = refused_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    rt_go = 1'b0;
    clr_go = 1'b0;
    rd_done = 1'b0;
    cnt_zero = (cnt_r == '0);
    // one wait state so read data and pready leave flops
    acc = psel && penable && !pready_r;

    if (acc) begin
      pready_nxt = 1'b1;
      prdata_nxt = '0;
      if (pwrite) begin
        if (paddr == REG_CTRL) begin
          chain_nxt = pwdata[CTRL_CHAIN];
          clr_go = pwdata[CTRL_CLEAR];
          rd_go = pwdata[CTRL_READ];
          rt_go = pwdata[CTRL_REPLAY];
        end else if (paddr == REG_WDATA) begin
          wr_go = 1'b1;
          if (state_r == AFC_IDLE) begin
            wdata_nxt = pwdata[DATA_W-1:0];
          end
        end else if (paddr == REG_STATUS) begin
          if (pwdata[ST_REFUSED]) begin
            refused_nxt = 1'b0;
          end
        end else if (paddr != REG_RDATA) begin
          pslverr_nxt = 1'b1;
        end
      end else begin
        if (paddr == REG_CTRL) begin
          prdata_nxt[CTRL_CHAIN] = chain_r;
        end else if (paddr == REG_WDATA) begin
          prdata_nxt[DATA_W-1:0] = wdata_r;
        end else if (paddr == REG_RDATA) begin
          prdata_nxt[DATA_W-1:0] = rword_r;
          rvalid_nxt = 1'b0;
        end else if (paddr == REG_STATUS) begin
          prdata_nxt[ST_BUSY] = (state_r != AFC_IDLE);
          prdata_nxt[ST_READY] = ready_r;
          prdata_nxt[ST_FULL_N] = full_s;
          prdata_nxt[ST_EMPTY_N] = empty_s;
          prdata_nxt[ST_HALF_N] = half_s;
          prdata_nxt[ST_RVALID] = rvalid_r;
          prdata_nxt[ST_REFUSED] = refused_r;
        end else begin
          pslverr_nxt = 1'b1;
        end
      end
    end

    case (state_r)
      AFC_IDLE: begin
        if (clr_go) begin
          state_nxt = AFC_CLR_LOW;
          cnt_nxt = LD_CLR_LOW;
          clear_n_nxt = 1'b0;
          ready_nxt = 1'b0;
        end else if (rt_go) begin
          // replay shares the first-load pin, so chain mode forbids it
          if (!ready_r || chain_r) begin
            refused_nxt = 1'b1;
          end else begin
            state_nxt = AFC_RT_LOW;
            cnt_nxt = LD_REPLAY_LOW;
            replay_n_nxt = 1'b0;
          end
        end else if (rd_go) begin
          if (!ready_r || !empty_s) begin
            refused_nxt = 1'b1;
          end else begin
            state_nxt = AFC_RD_LOW;
            cnt_nxt = LD_STROBE_LOW;
            rd_n_nxt = 1'b0;
          end
        end else if (wr_go) begin
          if (!ready_r || !full_s) begin
            refused_nxt = 1'b1;
          end else begin
            state_nxt = AFC_WR_SETUP;
            cnt_nxt = LD_DATA_SETUP;
          end
        end
      end
      AFC_CLR_LOW: begin
        if (cnt_zero) begin
          state_nxt = AFC_CLR_HOLD;
          cnt_nxt = LD_CLR_HOLD;
          clear_n_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      AFC_CLR_HOLD: begin
        if (cnt_zero) begin
          state_nxt = AFC_IDLE;
          ready_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      AFC_WR_SETUP: begin
        if (cnt_zero) begin
          state_nxt = AFC_WR_LOW;
          cnt_nxt = LD_STROBE_LOW;
          wr_n_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      AFC_WR_LOW: begin
        if (cnt_zero) begin
          state_nxt = AFC_WR_HIGH;
          cnt_nxt = LD_RECOVER;
          wr_n_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      AFC_RD_LOW: begin
        if (cnt_zero) begin
          state_nxt = AFC_RD_HIGH;
          cnt_nxt = LD_RECOVER;
          rd_n_nxt = 1'b1;
          rd_done = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      AFC_RT_LOW: begin
        if (cnt_zero) begin
          state_nxt = AFC_RT_HIGH;
          cnt_nxt = LD_RECOVER;
          replay_n_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      // recovery lets the device flags settle through the synchroniser
      AFC_WR_HIGH, AFC_RD_HIGH, AFC_RT_HIGH: begin
        if (cnt_zero) begin
          state_nxt = AFC_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = AFC_IDLE;
      end
    endcase

    // a command that lands while busy is dropped and reported
    if (state_r != AFC_IDLE && (clr_go || rt_go || rd_go || wr_go)) begin
      refused_nxt = 1'b1;
    end
    // sampled late in the strobe low so access time has passed the sync
    if (rd_done) begin
      rword_nxt = rdata_s;
      rvalid_nxt = 1'b1;
    end
    // single mode pulls the chain input low; chain mode marks first device
    chain_in_n_nxt = chain_nxt;
    if (chain_nxt) begin
      replay_n_nxt = 1'b0;
    end else if (chain_r) begin
      replay_n_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // clear is held low from reset and the sequence runs on release
      state_r <= AFC_CLR_LOW;
      cnt_r <= LD_CLR_LOW;
      clear_n_r <= 1'b0;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      replay_n_r <= 1'b1;
      chain_r <= CHAIN_RST;
      chain_in_n_r <= CHAIN_RST;
      wdata_r <= '0;
      rword_r <= '0;
      ready_r <= 1'b0;
      rvalid_r <= 1'b0;
      refused_r <= 1'b0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      clear_n_r <= clear_n_nxt;
      wr_n_r <= wr_n_nxt;
      rd_n_r <= rd_n_nxt;
      replay_n_r <= replay_n_nxt;
      chain_r <= chain_nxt;
      chain_in_n_r <= chain_in_n_nxt;
      wdata_r <= wdata_nxt;
      rword_r <= rword_nxt;
      ready_r <= ready_nxt;
      rvalid_r <= rvalid_nxt;
      refused_r <= refused_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign clear_in_n = clear_n_r;
  assign write_strobe_n = wr_n_r;
  assign read_strobe_n = rd_n_r;
  assign replay_n = replay_n_r;
  assign chain_in_n = chain_in_n_r;
  assign write_data = wdata_r;

endmodule

// file: test/afc_host_checker.sv
// assertion checker for the fifo host controller
`timescale 1ns/1ps
module afc_host_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // fifo pins
  input wire logic clear_in_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic replay_n,
  input wire logic chain_in_n,
  input wire logic [afc_pkg::DATA_W-1:0] write_data,
  input wire logic full_flag_n,
  input wire logic empty_flag_n
);
  import afc_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_clear_strobes: assert property (!clear_in_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe low during clear");
  a_clear_hold: assert property ($rose(clear_in_n) |-> (write_strobe_n && read_strobe_n)[*3])
    else $error("strobe moved too soon after clear");
  a_clear_length: assert property ($rose(clear_in_n) |-> !$past(clear_in_n, 9))
    else $error("clear pulse too short");
  a_wdata_stable: assert property (!write_strobe_n |=> $stable(write_data))
    else $error("write data moved under strobe");
  a_wr_width: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*8] ##1 write_strobe_n)
    else $error("write strobe width wrong");
  a_rd_width: assert property ($fell(read_strobe_n) |-> (!read_strobe_n)[*8] ##1 read_strobe_n)
    else $error("read strobe width wrong");
  a_no_wr_full: assert property ($fell(write_strobe_n) |-> full_flag_n && $past(full_flag_n, 5))
    else $error("write strobe while full");
  a_no_rd_empty: assert property ($fell(read_strobe_n) |-> empty_flag_n && $past(empty_flag_n, 4))
    else $error("read strobe while empty");
  a_replay_quiet: assert property (!replay_n && !chain_in_n |-> write_strobe_n && read_strobe_n)
    else $error("strobe low during replay");
  a_chain_first: assert property (chain_in_n && $past(chain_in_n) |-> !replay_n)
    else $error("first-load high in chain mode");
  a_pready_once: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("pready not a single pulse");
endmodule

bind afc_host afc_host_checker u_afc_host_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .clear_in_n(clear_in_n), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .replay_n(replay_n), .chain_in_n(chain_in_n),
  .write_data(write_data), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n));

// file: test/afc_fifo_model.sv
// behavioural model of the strobe-driven 9-bit fifo device
`timescale 1ns/1ps
module afc_fifo_model #(
  parameter int DEPTH = 512
) (
  // control pins
  input wire logic clear_in_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic replay_n,
  input wire logic chain_in_n,
  input wire logic [afc_pkg::DATA_W-1:0] write_data,
  // flags and data
  output logic full_flag_n,
  output logic empty_flag_n,
  output logic half_level_flag_n,
  output logic [afc_pkg::DATA_W-1:0] read_data
);
  import afc_pkg::*;
  logic [DATA_W-1:0] mem [DEPTH];
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  bit wok = 0;
  bit rok = 0;
  // this part stands first in any chain, so a clear hands it both tokens
  bit wtok = 1;
  bit rtok = 1;
  // full and empty flags lag the pointer move by a few ns, as on the part
  assign #4 full_flag_n = (cnt != DEPTH);
  assign #4 empty_flag_n = (cnt != 0);
  initial half_level_flag_n = 1'b1;
  initial read_data = '0;
  always @(clear_in_n) if (!clear_in_n) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    half_level_flag_n = 1'b1;
    wtok = 1'b1;
    rtok = 1'b1;
  end
  always @(negedge write_strobe_n) begin
    wok = clear_in_n && (cnt < DEPTH) && (!chain_in_n || wtok);
    if (wok && cnt >= DEPTH / 2) half_level_flag_n = 1'b0;
  end
  always @(posedge write_strobe_n) if (wok) begin
    mem[wp] = write_data;
    wp = (wp + 1) % DEPTH;
    cnt++;
    // last location passes the write token on down the chain
    if (chain_in_n && wp == 0) wtok = 0;
    wok = 0;
  end
  always @(negedge read_strobe_n) begin
    rok = clear_in_n && (cnt > 0) && (!chain_in_n || rtok);
    if (rok) read_data <= #5 mem[rp];
  end
  // released bus shows the inverse of its last value, never a guess
  always @(posedge read_strobe_n) begin
    if (rok) rp = (rp + 1) % DEPTH;
    if (rok) cnt--;
    if (rok && chain_in_n && rp == 0) rtok = 0;
    if (cnt <= DEPTH / 2) half_level_flag_n = 1'b1;
    rok = 0;
    read_data = ~read_data;
  end
  // chain entry moves both pins in one step; let them settle before deciding
  always @(negedge replay_n) begin
    #1;
    if (!chain_in_n && !replay_n) begin
      rp = 0;
      cnt = wp;
      half_level_flag_n = !(cnt > DEPTH / 2);
    end
  end
endmodule

// file: test/afc_host_tb_top.sv
// self-checking bench for the fifo host controller
`timescale 1ns/1ps
module afc_host_tb_top;
  import afc_pkg::*;
  localparam int DEPTH = 512;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, re;
  logic clear_in_n, write_strobe_n, read_strobe_n, replay_n, chain_in_n;
  logic full_flag_n, empty_flag_n, half_level_flag_n;
  logic [DATA_W-1:0] write_data, read_data;
  int fail_count = 0;
  int num_checks = 0;

  afc_host u_afc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clear_in_n(clear_in_n), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .replay_n(replay_n), .chain_in_n(chain_in_n),
    .write_data(write_data), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .half_level_flag_n(half_level_flag_n), .read_data(read_data));
  afc_fifo_model #(.DEPTH(DEPTH)) u_afc_fifo_model (.clear_in_n(clear_in_n),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .replay_n(replay_n),
    .chain_in_n(chain_in_n), .write_data(write_data), .full_flag_n(full_flag_n),
    .empty_flag_n(empty_flag_n), .half_level_flag_n(half_level_flag_n), .read_data(read_data));

  initial forever #5 pclk = ~pclk;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      end_of_test();
    end
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rv[ST_BUSY] !== 1'b0 && n < 60);
    if (n >= 60) begin
      fail_count++;
      end_of_test();
    end
  endtask

  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask

  task automatic st(input int b, input logic e, input string m);
    apb(1'b0, REG_STATUS, 32'h0);
    chk({31'h0, rv[b]}, {31'h0, e}, m);
  endtask

  task automatic get(input logic [8:0] e);
    cmd(REG_CTRL, 32'h2);
    apb(1'b0, REG_RDATA, 32'h0);
    chk(rv, {23'h0, e}, "read word");
  endtask

  task automatic t_reset;
    idle();
    chk({27'h0, rv[4:0]}, 32'h16, "status after clear");
    $display("test reset done");
  endtask

  task automatic t_order;
    logic [8:0] v [3];
    v = '{9'h1A5, 9'h05A, 9'h1FF};
    foreach (v[i]) cmd(REG_WDATA, {23'h0, v[i]});
    st(ST_EMPTY_N, 1'b1, "empty after write");
    foreach (v[i]) get(v[i]);
    st(ST_EMPTY_N, 1'b0, "empty after drain");
    cmd(REG_CTRL, 32'h2);
    st(ST_REFUSED, 1'b1, "read while empty");
    cmd(REG_STATUS, 32'h40);
    st(ST_REFUSED, 1'b0, "refused cleared");
    $display("test order done");
  endtask

  // rewind goes to the first location since the last clear, so start clean
  task automatic t_replay;
    cmd(REG_CTRL, 32'h1);
    cmd(REG_WDATA, 32'h011);
    cmd(REG_WDATA, 32'h122);
    get(9'h011);
    cmd(REG_CTRL, 32'h4);
    get(9'h011);
    get(9'h122);
    $display("test replay done");
  endtask

  // fill to half, past half, replay, then full and one refused write
  task automatic t_fill;
    cmd(REG_WDATA, 32'h0AA);
    cmd(REG_CTRL, 32'h1);
    st(ST_EMPTY_N, 1'b0, "empty after clear");
    for (int i = 0; i < DEPTH / 2; i++) cmd(REG_WDATA, 32'(i));
    st(ST_HALF_N, 1'b1, "half at half");
    cmd(REG_WDATA, 32'h1FF);
    st(ST_HALF_N, 1'b0, "half past half");
    get(9'h000);
    st(ST_HALF_N, 1'b1, "half after read");
    cmd(REG_CTRL, 32'h4);
    st(ST_HALF_N, 1'b0, "half after replay");
    for (int i = 0; i < DEPTH / 2 - 2; i++) cmd(REG_WDATA, 32'h055);
    st(ST_FULL_N, 1'b1, "full one short");
    cmd(REG_WDATA, 32'h066);
    st(ST_FULL_N, 1'b0, "full at depth");
    cmd(REG_WDATA, 32'h077);
    st(ST_REFUSED, 1'b1, "write while full");
    cmd(REG_STATUS, 32'h40);
    get(9'h000);
    st(ST_FULL_N, 1'b1, "full released");
    $display("test fill done");
  endtask

  task automatic t_bus_chain;
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, re}, 32'h1, "unmapped error");
    apb(1'b1, REG_RDATA, 32'h0);
    chk({31'h0, re}, 32'h0, "rdata write");
    cmd(REG_CTRL, 32'h8);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rv, 32'h8, "chain bit");
    chk({30'h0, chain_in_n, replay_n}, 32'h2, "chain pins");
    cmd(REG_CTRL, 32'hC);
    st(ST_REFUSED, 1'b1, "replay in chain");
    cmd(REG_CTRL, 32'h0);
    cmd(REG_STATUS, 32'h40);
    chk({30'h0, chain_in_n, replay_n}, 32'h1, "single pins");
    $display("test bus and chain done");
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_order();
    t_replay();
    t_fill();
    t_bus_chain();
    end_of_test();
  end
endmodule
